//--- core/debug_halt_behaviour_control.sv
// debug halt control: session init, break, reset masking, watchdog hold, irq gating
// Notes on behaviour
// - session start loads pc from reset vector
// - session start clears other general registers
// - low-power left on wake or break
// - jtag: pin reset masked while halted
// - single-line: pin reset not masked
// - wait low during break: access times out
// - watchdog holds while halted
// - watchdog resumes from held value on restart
// - peripherals keep running while halted
// - maskable interrupts refused while halted
// - pending interrupts taken right after restart
module debug_halt_behaviour_control #(
  parameter int unsigned TIMEOUT_CYC = debug_halt_pkg::ACC_TIMEOUT_CYC
) (
  input  wire logic                                    sys_clk,
  input  wire logic                                    rst_n,
  input  wire logic                                    external_reset_pin_n,
  input  wire logic                                    wait_pin_n,
  input  wire debug_halt_pkg::dbg_cmd_t                dbg_cmd,
  input  wire logic [debug_halt_pkg::DATA_W-1:0]       reset_vector,
  input  wire logic                                    sleep_req,
  input  wire logic                                    wake_src,
  input  wire logic [debug_halt_pkg::IRQ_W-1:0]        irq_pending,
  output logic                                         halted,
  output logic                                         low_power,
  output logic                                         core_reset,
  output logic [debug_halt_pkg::DATA_W-1:0]            pc_out,
  output logic [debug_halt_pkg::NUM_GPR*debug_halt_pkg::DATA_W-1:0] gpr_out,
  output logic [debug_halt_pkg::WATCHDOG_W-1:0]        watchdog_counter,
  output logic [debug_halt_pkg::IRQ_W-1:0]             irq_accept,
  output logic                                         periph_run,
  output debug_halt_pkg::dbg_rsp_t                     dbg_rsp
);
  import debug_halt_pkg::*;

  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYC - 1);

  // reset release and pin synchronisers
  logic       rst_s1_r;
  logic       rst_s2_r;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic       rst_sync_n;
  logic       pin_rst_low;
  logic       pin_wait_low;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_sync_n = rst_s2_r;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1_r <= 2'b11;
      pin_s2_r <= 2'b11;
    end else begin
      pin_s1_r <= {external_reset_pin_n, wait_pin_n};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign pin_rst_low  = ~pin_s2_r[1];
  assign pin_wait_low = ~pin_s2_r[0];

  // run state and halted indication
  run_state_t state_r;
  run_state_t state_nxt;
  logic       link_single_r;
  logic       link_single_nxt;
  logic       halted_r;
  logic       halted_nxt;
  logic       low_power_r;
  logic       low_power_nxt;
  logic       do_reset;

  // a masked pin reset is simply dropped, not deferred to restart
  always_comb begin
    do_reset = pin_rst_low && !(state_r == ST_HALT && !link_single_r);
  end

  always_comb begin
    state_nxt       = state_r;
    link_single_nxt = link_single_r;
    if (dbg_cmd.session_start) begin
      link_single_nxt = dbg_cmd.link_single;
    end
    if (do_reset) begin
      state_nxt = ST_RUN;
    end else if (dbg_cmd.session_start) begin
      state_nxt = ST_HALT;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (dbg_cmd.break_req) begin
            state_nxt = ST_HALT;
          end else if (sleep_req) begin
            state_nxt = ST_SLEEP;
          end
        end
        ST_HALT: begin
          if (dbg_cmd.resume_req) begin
            state_nxt = ST_RUN;
          end
        end
        ST_SLEEP: begin
          if (dbg_cmd.break_req) begin
            state_nxt = ST_HALT;
          end else if (wake_src) begin
            state_nxt = ST_RUN;
          end
        end
        default: state_nxt = ST_RUN;
      endcase
    end
    // decoded ahead so both outputs leave straight from flops
    halted_nxt    = (state_nxt == ST_HALT);
    low_power_nxt = (state_nxt == ST_SLEEP);
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r       <= ST_RUN;
      link_single_r <= 1'b0;
      halted_r      <= 1'b0;
      low_power_r   <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      link_single_r <= link_single_nxt;
      halted_r      <= halted_nxt;
      low_power_r   <= low_power_nxt;
    end
  end

  // register initialisation at session start
  logic [DATA_W-1:0]         pc_r;
  logic [DATA_W-1:0]         pc_nxt;
  logic [NUM_GPR*DATA_W-1:0] gpr_r;
  logic [NUM_GPR*DATA_W-1:0] gpr_nxt;

  always_comb begin
    pc_nxt  = pc_r;
    gpr_nxt = gpr_r;
    if (dbg_cmd.session_start) begin
      pc_nxt  = reset_vector;
      gpr_nxt = {NUM_GPR{GPR_CLEAR}};
    end
  end

  // outside a session these start as zero too; the real core leaves them undefined
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pc_r  <= GPR_CLEAR;
      gpr_r <= {NUM_GPR{GPR_CLEAR}};
    end else begin
      pc_r  <= pc_nxt;
      gpr_r <= gpr_nxt;
    end
  end

  // watchdog, interrupts, memory access
  logic [WATCHDOG_W-1:0] watchdog_r;
  logic [WATCHDOG_W-1:0] watchdog_nxt;
  logic [IRQ_W-1:0]      irq_r;
  logic [IRQ_W-1:0]      irq_nxt;
  logic                  busy_r;
  logic                  busy_nxt;
  logic [TMO_W-1:0]      tmo_r;
  logic [TMO_W-1:0]      tmo_nxt;
  logic                  done_r;
  logic                  done_nxt;
  logic                  tout_r;
  logic                  tout_nxt;
  logic                  halt_now;

  assign halt_now = (state_r == ST_HALT);

  always_comb begin
    watchdog_nxt = watchdog_r;
    irq_nxt  = '0;
    busy_nxt = busy_r;
    tmo_nxt  = tmo_r;
    done_nxt = 1'b0;
    tout_nxt = 1'b0;
    if (do_reset) begin
      watchdog_nxt = WATCHDOG_START;
    end else if (!halt_now) begin
      watchdog_nxt = watchdog_r + WATCHDOG_STEP;
    end
    // taken on the first running cycle since pending lines stay high
    if (!halt_now && state_nxt != ST_HALT) begin
      irq_nxt = irq_pending;
    end
    if (!busy_r) begin
      if (dbg_cmd.mem_req) begin
        busy_nxt = 1'b1;
        tmo_nxt  = '0;
      end
    end else if (!pin_wait_low) begin
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
    end else if (tmo_r == TMO_LAST) begin
      busy_nxt = 1'b0;
      tout_nxt = 1'b1;
    end else begin
      tmo_nxt = tmo_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      watchdog_r <= WATCHDOG_START;
      irq_r  <= '0;
      busy_r <= 1'b0;
      tmo_r  <= '0;
      done_r <= 1'b0;
      tout_r <= 1'b0;
    end else begin
      watchdog_r <= watchdog_nxt;
      irq_r  <= irq_nxt;
      busy_r <= busy_nxt;
      tmo_r  <= tmo_nxt;
      done_r <= done_nxt;
      tout_r <= tout_nxt;
    end
  end

  // registered outputs
  logic core_reset_r;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_reset_r <= 1'b0;
    end else begin
      core_reset_r <= do_reset;
    end
  end

  assign halted           = halted_r;
  assign low_power        = low_power_r;
  assign core_reset       = core_reset_r;
  assign pc_out           = pc_r;
  assign gpr_out          = gpr_r;
  assign watchdog_counter = watchdog_r;
  assign irq_accept       = irq_r;
  assign periph_run       = rst_sync_n;
  assign dbg_rsp          = {done_r, tout_r};
endmodule

//--- core/debug_halt_pkg.sv
// shared types and constants for the debug halt control block
package debug_halt_pkg;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned WATCHDOG_W    = 16;
  localparam int unsigned NUM_GPR       = 15;
  localparam int unsigned IRQ_W         = 8;
  localparam logic [DATA_W-1:0] GPR_CLEAR = 32'h0000_0000;
  localparam logic [WATCHDOG_W-1:0] WATCHDOG_START = 16'h0000;
  localparam logic [WATCHDOG_W-1:0] WATCHDOG_STEP  = 16'h0001;
  // memory access give-up time while the wait pin is held low
  localparam int unsigned ACC_TIMEOUT_US = 100;
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned ACC_TIMEOUT_CYC = ACC_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned TMO_W          = 12;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_HALT  = 2'b01,
    ST_SLEEP = 2'b10
  } run_state_t;

  typedef struct packed {
    logic session_start;  // one-cycle pulse at debug start-up
    logic link_single;    // 1 = single-line link, 0 = jtag
    logic break_req;      // forced break pulse
    logic resume_req;     // restart user program pulse
    logic mem_req;        // memory access request pulse
  } dbg_cmd_t;

  typedef struct packed {
    logic mem_done;
    logic mem_timeout;
  } dbg_rsp_t;
endpackage

//--- test/debug_halt_behaviour_control_properties.sv
// port-level checks for the debug halt control block
module debug_halt_checker
  import debug_halt_pkg::*;
#(parameter int unsigned TIMEOUT_CYC = 8) (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic                    external_reset_pin_n,
  input wire logic                    wait_pin_n,
  input wire dbg_cmd_t                dbg_cmd,
  input wire logic [DATA_W-1:0]       reset_vector,
  input wire logic [IRQ_W-1:0]        irq_pending,
  input wire logic                    halted,
  input wire logic                    core_reset,
  input wire logic [DATA_W-1:0]       pc_out,
  input wire logic [NUM_GPR*DATA_W-1:0] gpr_out,
  input wire logic [WATCHDOG_W-1:0]   watchdog_counter,
  input wire logic [IRQ_W-1:0]        irq_accept,
  input wire logic                    periph_run,
  input wire dbg_rsp_t                dbg_rsp
);
  localparam int T_LO = TIMEOUT_CYC;
  localparam int T_HI = TIMEOUT_CYC + 2;
  logic       link_r;
  logic [2:0] pin_r;
  logic       ok;
  // pin sync delay means a recent low can still act
  assign ok = (pin_r == 3'h7) && external_reset_pin_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_r <= 1'b0;
      pin_r  <= 3'h7;
    end else begin
      pin_r <= {pin_r[1:0], external_reset_pin_n};
      if (dbg_cmd.session_start) begin
        link_r <= dbg_cmd.link_single;
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_break_halts: assert property (dbg_cmd.break_req && ok |=> halted)
    else $error("break did not halt");
  a_resume_irq: assert property (dbg_cmd.resume_req && halted && ok && !dbg_cmd.session_start
    |=> !halted ##[0:1] irq_accept == irq_pending)
    else $error("pending irq not taken on restart");
  a_session_init: assert property (dbg_cmd.session_start && ok
    |=> pc_out == $past(reset_vector) && gpr_out == '0 && halted)
    else $error("session start init wrong");
  a_watchdog_frozen: assert property (halted && $past(halted) |-> $stable(watchdog_counter))
    else $error("watchdog moved while halted");
  a_watchdog_counts: assert property (periph_run && $past(periph_run) && !halted && !$past(halted)
    && !core_reset && !$past(core_reset)
    |-> watchdog_counter == $past(watchdog_counter) + WATCHDOG_STEP)
    else $error("watchdog not counting");
  a_irq_refused: assert property (halted |-> irq_accept == '0 && periph_run)
    else $error("irq taken or peripherals stopped while halted");
  a_jtag_mask: assert property (halted && !link_r |=> !core_reset)
    else $error("pin reset not masked");
  a_single_reset: assert property (link_r && $fell(external_reset_pin_n) |-> ##[2:4] core_reset)
    else $error("pin reset missing");
  a_mem_done: assert property (dbg_cmd.mem_req && wait_pin_n && $past(wait_pin_n, 3)
    |-> ##2 dbg_rsp.mem_done)
    else $error("access not done");
  a_mem_timeout: assert property (dbg_cmd.mem_req && !wait_pin_n && !$past(wait_pin_n, 3)
    |-> ##[T_LO:T_HI] dbg_rsp.mem_timeout)
    else $error("access did not time out");
endmodule
bind debug_halt_behaviour_control debug_halt_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.*);

//--- test/emu_model.sv
// emulator-side model issuing debug command pulses
module emu_model
  import debug_halt_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic external_reset_pin_n,
  input  wire logic wait_pin_n,
  output dbg_cmd_t  cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // flash_control_unit firmware load assumed done outside
  // clock setup never touched while running
  initial cmd = '0;
  // k: 0 start, 1 break, 2 resume, 3 memory access
  task automatic issue(input int k, input logic single);
    dbg_cmd_t c;
    c = '0;
    c.link_single = single;
    case (k)
      0: c.session_start = 1'b1;
      1: c.break_req = external_reset_pin_n && wait_pin_n;
      2: c.resume_req = 1'b1;
      default: c.mem_req = 1'b1;
    endcase
    cmd <= c;
    @(posedge sys_clk);
    cmd <= '0;
    @(posedge sys_clk);
  endtask
endmodule

//--- test/debug_halt_behaviour_control_bench.sv
// self-checking bench for the debug halt control block
module debug_halt_behaviour_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import debug_halt_pkg::*;
  logic sys_clk = 0, rst_n = 0, external_reset_pin_n = 1, wait_pin_n = 1;
  logic sleep_req = 0, wake_src = 0, halted, low_power, core_reset, periph_run;
  logic [DATA_W-1:0] reset_vector = '0, pc_out;
  logic [IRQ_W-1:0] irq_pending = '0, irq_accept;
  logic [NUM_GPR*DATA_W-1:0] gpr_out;
  logic [WATCHDOG_W-1:0] watchdog_counter, w;
  dbg_cmd_t dbg_cmd;
  dbg_rsp_t dbg_rsp, exp_q[$];
  int n_mismatch = 0, tests_run = 0, cycles = 0, seed = 32'h0babe796;
  always #20 sys_clk = ~sys_clk;
  debug_halt_behaviour_control #(.TIMEOUT_CYC(8)) i_dut (.*);
  emu_model i_emu (.cmd(dbg_cmd), .*);
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // responses pair with notes in issue order
  always @(posedge sys_clk) begin
    if (cycles++ > 5000) begin
      n_mismatch++;
      complete_run();
    end
    // outputs are unknown until the first edge in reset
    if (rst_n && dbg_rsp !== 2'b00) check(dbg_rsp, exp_q.size() ? exp_q.pop_front() : 2'b11);
  end
  initial begin
    tick(8);
    rst_n <= 1;
    tick(4);
    reset_vector <= $random(seed);
    irq_pending <= IRQ_W'($random(seed)) | 8'h01;
    tick(1);
    i_emu.issue(0, 0);
    check(pc_out, reset_vector);
    check(|gpr_out, 0);
    w = watchdog_counter;
    tick(5);
    check(watchdog_counter, w);
    check(irq_accept, 0);
    check(periph_run, 1);
    external_reset_pin_n <= 0;
    tick(6);
    check(halted, 1);
    check(core_reset, 0);
    external_reset_pin_n <= 1;
    for (int i = 0; i < 2; i++) begin
      wait_pin_n <= !i[0];
      tick(4);
      exp_q.push_back(i ? 2'b01 : 2'b10);
      i_emu.issue(3, 0);
      tick(14);
    end
    wait_pin_n <= 1;
    tick(4);
    w = watchdog_counter;
    i_emu.issue(2, 0);
    tick(1);
    check(irq_accept, irq_pending);
    check(watchdog_counter, WATCHDOG_W'(w + WATCHDOG_STEP));
    sleep_req <= 1;
    tick(1);
    sleep_req <= 0;
    tick(1);
    check(low_power, 1);
    i_emu.issue(1, 0);
    check({halted, low_power}, 2'b10);
    i_emu.issue(2, 0);
    sleep_req <= 1;
    tick(1);
    sleep_req <= 0;
    tick(1);
    check(low_power, 1);
    wake_src <= 1;
    tick(2);
    check(low_power, 0);
    wake_src <= 0;
    i_emu.issue(0, 1);
    external_reset_pin_n <= 0;
    tick(5);
    check(halted, 0);
    check(core_reset, 1);
    external_reset_pin_n <= 1;
    tick(4);
    // every noted access must have been answered
    check(exp_q.size(), 0);
    complete_run();
  end
endmodule
